// ### pkg/bafe_defs.svh
/*
 Constants for the battery front-end register bank: register indices,
 field positions, reset values and writable-bit masks.
 Assumes inclusion by bare name from pkg/ on the include path.
*/
`ifndef BAFE_DEFS_SVH
`define BAFE_DEFS_SVH

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define BAFE_ADDR_CFG_WAKE 8'h00
`define BAFE_ADDR_PROT_STAT 8'h01
`define BAFE_ADDR_CELL_BAL 8'h02
`define BAFE_ADDR_ANA_OUT 8'h03
`define BAFE_ADDR_FET_CTL 8'h04
`define BAFE_ADDR_DSG_SETUP 8'h05
`define BAFE_ADDR_CHG_SETUP 8'h06
`define BAFE_ADDR_FEATURE 8'h07
`define BAFE_ADDR_UNLOCK 8'h08
`define BAFE_ADDR_LAST 8'h08

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BAFE_CFG_ONE_BIT 5
`define BAFE_CFG_WAKE_BIT 4
`define BAFE_PS_XOT_BIT 5
`define BAFE_PS_IOT_BIT 4
`define BAFE_PS_LDF_BIT 3
`define BAFE_PS_DSC_BIT 2
`define BAFE_PS_DOC_BIT 1
`define BAFE_PS_COC_BIT 0
`define BAFE_FET_SLEEP_BIT 7
`define BAFE_FET_LDMON_BIT 6
`define BAFE_FET_CHG_BIT 1
`define BAFE_FET_DSG_BIT 0
`define BAFE_DSG_NOAUTO_OC_BIT 7
`define BAFE_DSG_NOAUTO_SC_BIT 4
`define BAFE_CHG_NOAUTO_OC_BIT 7
`define BAFE_FEAT_WAKE_POLARITY_BIT 0
`define BAFE_UNL_FEAT_BIT 7
`define BAFE_UNL_CHG_BIT 6
`define BAFE_UNL_DSG_BIT 5

// ----------------------------------------------------------------
// Writable masks and reset values
// ----------------------------------------------------------------
`define BAFE_MASK_CELL_BAL 8'h7e
`define BAFE_MASK_ANA_OUT 8'hcf
`define BAFE_MASK_FET_CTL 8'hc3
`define BAFE_MASK_UNLOCK 8'hf8
`define BAFE_RST_CTRL 8'h00
`define BAFE_RST_FEATURE 8'h01

`endif

// ### pkg/bafe_pkg.sv
/*
 Types shared by both ends of the battery front-end register link.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package bafe_pkg;
   // ----------------------------------------------------------------
   // Basic types
   // ----------------------------------------------------------------
   typedef logic [7:0] bafe_byte_t; // One register or index
   typedef enum logic {bafe_op_read, bafe_op_write} bafe_op_e; // Transfer kind
endpackage : bafe_pkg

// ### pkg/bafe_link_if.sv
/*
 Host-device register link: one-cycle request, one-cycle ack with data.
 Assumes both ends share clk_sys_in.
*/
interface bafe_link_if;
   import bafe_pkg::*;
   // ----------------------------------------------------------------
   // Link signals
   // ----------------------------------------------------------------
   logic req; // Request pulse from host
   bafe_op_e op; // Read or write
   bafe_byte_t addr; // Register index
   bafe_byte_t wdata; // Write byte
   logic ack; // One-cycle answer pulse
   bafe_byte_t rdata; // Read byte, valid with ack
   modport host (output req, output op, output addr, output wdata, input ack, input rdata);
   modport dev (input req, input op, input addr, input wdata, output ack, output rdata);
endinterface : bafe_link_if

// ### rtl/bafe_device.sv
/*
 Device end of the battery front-end register bank.
 Assumes synchronous condition inputs and one request in flight.
*/
`include "bafe_defs.svh"

module bafe_device (
   input wire logic clk_sys_in, // System clock
   input wire logic arst_n_in, // Async reset, active low
   bafe_link_if.dev link, // Register link
   input wire logic wake_pin_in, // Wake pin above threshold
   input wire logic ext_overtemp_in, // External over-temp condition
   input wire logic int_overtemp_in, // Internal over-temp condition
   input wire logic dsg_short_in, // Discharge short-circuit event
   input wire logic dsg_overcurrent_in, // Discharge overcurrent event
   input wire logic chg_overcurrent_in, // Charge overcurrent event
   output logic [7:0] cell_balance_out, // Balance switch bits
   output logic [3:0] analog_sel_out, // Analog output select
   output logic charge_switch_drive_out, // Charge FET drive
   output logic discharge_switch_drive_out, // Discharge FET drive
   output logic sleep_out, // Forced sleep request
   output logic load_monitor_connect_en_out, // Load monitor connection
   output logic [7:0] discharge_setup_out, // Discharge protection setup
   output logic [7:0] charge_setup_out, // Charge protection setup
   output logic [7:0] feature_config_out // Feature configuration
);
   import bafe_pkg::*;

   // ----------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------
   bafe_byte_t cell_bal_reg; // Balance switches
   bafe_byte_t ana_out_reg; // Analog select and user flags
   bafe_byte_t fet_ctl_reg; // FET drive, monitor, sleep
   bafe_byte_t dsg_setup_reg; // Discharge setup
   bafe_byte_t chg_setup_reg; // Charge setup
   bafe_byte_t feature_reg; // Feature configuration
   bafe_byte_t unlock_reg; // Write unlock and user flags
   bafe_byte_t prot_stat_reg; // Sticky protection flags
   logic wake_pin_reg; // Previous wake pin sample
   logic ack_reg; // Answer pulse
   bafe_byte_t rdata_reg; // Answer data

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   logic wr_stb; // Write request this cycle
   logic rd_stb; // Read request this cycle
   logic rd_prot; // Read of protection status
   logic wake_pol; // Wake polarity
   logic wake_status; // Pin seen through polarity
   logic wake_edge; // Active wake edge
   logic auto_trip; // Protection event with auto response on
   bafe_byte_t prot_set; // Conditions setting flags
   bafe_byte_t cfg_wake_val; // Live config/wake byte

   assign wr_stb = link.req && (link.op == bafe_op_write);
   assign rd_stb = link.req && (link.op == bafe_op_read);
   assign rd_prot = rd_stb && (link.addr == `BAFE_ADDR_PROT_STAT);
   assign wake_pol = feature_reg[`BAFE_FEAT_WAKE_POLARITY_BIT];
   // Status seen through polarity
   assign wake_status = wake_pol ? wake_pin_in : !wake_pin_in;
   // Rise with polarity one, fall with polarity zero
   assign wake_edge = wake_pol ? (wake_pin_in && !wake_pin_reg) : (!wake_pin_in && wake_pin_reg);
   // Auto response disabled per event by its setup bit
   assign auto_trip = (dsg_overcurrent_in && !dsg_setup_reg[`BAFE_DSG_NOAUTO_OC_BIT])
      || (dsg_short_in && !dsg_setup_reg[`BAFE_DSG_NOAUTO_SC_BIT])
      || (chg_overcurrent_in && !chg_setup_reg[`BAFE_CHG_NOAUTO_OC_BIT]);

   // Flag set terms; load fail gated by the monitor enable
   always_comb begin
      prot_set = 8'h00;
      prot_set[`BAFE_PS_XOT_BIT] = ext_overtemp_in;
      prot_set[`BAFE_PS_IOT_BIT] = int_overtemp_in;
      prot_set[`BAFE_PS_LDF_BIT] = (dsg_short_in || dsg_overcurrent_in)
         && fet_ctl_reg[`BAFE_FET_LDMON_BIT];
      prot_set[`BAFE_PS_DSC_BIT] = dsg_short_in;
      prot_set[`BAFE_PS_DOC_BIT] = dsg_overcurrent_in;
      prot_set[`BAFE_PS_COC_BIT] = chg_overcurrent_in;
   end

   // Live status byte, bit 5 always one
   always_comb begin
      cfg_wake_val = 8'h00;
      cfg_wake_val[`BAFE_CFG_ONE_BIT] = 1'b1;
      cfg_wake_val[`BAFE_CFG_WAKE_BIT] = wake_status;
   end

   // ----------------------------------------------------------------
   // Plain read/write registers
   // ----------------------------------------------------------------
   // Reserved bits masked so they always read zero
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cell_bal_reg <= `BAFE_RST_CTRL;
         ana_out_reg <= `BAFE_RST_CTRL;
         unlock_reg <= `BAFE_RST_CTRL;
      end else if (wr_stb) begin
         unique case (link.addr)
            `BAFE_ADDR_CELL_BAL: cell_bal_reg <= link.wdata & `BAFE_MASK_CELL_BAL;
            `BAFE_ADDR_ANA_OUT: ana_out_reg <= link.wdata & `BAFE_MASK_ANA_OUT;
            `BAFE_ADDR_UNLOCK: unlock_reg <= link.wdata & `BAFE_MASK_UNLOCK;
            default: ; // Other indices handled elsewhere or ignored
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Gated setup registers
   // ----------------------------------------------------------------
   // Writes while locked are silently dropped
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         dsg_setup_reg <= `BAFE_RST_CTRL;
         chg_setup_reg <= `BAFE_RST_CTRL;
         feature_reg <= `BAFE_RST_FEATURE;
      end else if (wr_stb) begin
         if (link.addr == `BAFE_ADDR_DSG_SETUP && unlock_reg[`BAFE_UNL_DSG_BIT]) begin
            dsg_setup_reg <= link.wdata;
         end
         if (link.addr == `BAFE_ADDR_CHG_SETUP && unlock_reg[`BAFE_UNL_CHG_BIT]) begin
            chg_setup_reg <= link.wdata;
         end
         if (link.addr == `BAFE_ADDR_FEATURE && unlock_reg[`BAFE_UNL_FEAT_BIT]) begin
            feature_reg <= link.wdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // Fet_drive_control and sleep
   // ----------------------------------------------------------------
   // Trip beats a same-cycle write so the FETs never re-arm into a fault
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         fet_ctl_reg <= `BAFE_RST_CTRL;
      end else begin
         if (wr_stb && link.addr == `BAFE_ADDR_FET_CTL) begin
            fet_ctl_reg <= link.wdata & `BAFE_MASK_FET_CTL;
         end
         if (wake_edge) begin
            fet_ctl_reg[`BAFE_FET_SLEEP_BIT] <= 1'b0;
         end
         if (auto_trip) begin
            fet_ctl_reg[`BAFE_FET_CHG_BIT] <= 1'b0;
            fet_ctl_reg[`BAFE_FET_DSG_BIT] <= 1'b0;
         end
      end
   end

   // Previous wake sample for edge detection
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wake_pin_reg <= 1'b0;
      end else begin
         wake_pin_reg <= wake_pin_in;
      end
   end

   // ----------------------------------------------------------------
   // Protection status flags
   // ----------------------------------------------------------------
   // Set wins over the read clear
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         prot_stat_reg <= 8'h00;
      end else if (rd_prot) begin
         prot_stat_reg <= prot_set; // Only live conditions survive
      end else begin
         prot_stat_reg <= prot_stat_reg | prot_set;
      end
   end

   // ----------------------------------------------------------------
   // Answer path
   // ----------------------------------------------------------------
   // Read returns the value before any clear; unmapped reads give zero
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ack_reg <= 1'b0;
         rdata_reg <= 8'h00;
      end else begin
         ack_reg <= link.req;
         if (rd_stb) begin
            unique case (link.addr)
               `BAFE_ADDR_CFG_WAKE: rdata_reg <= cfg_wake_val;
               `BAFE_ADDR_PROT_STAT: rdata_reg <= prot_stat_reg | prot_set;
               `BAFE_ADDR_CELL_BAL: rdata_reg <= cell_bal_reg;
               `BAFE_ADDR_ANA_OUT: rdata_reg <= ana_out_reg;
               `BAFE_ADDR_FET_CTL: rdata_reg <= fet_ctl_reg;
               `BAFE_ADDR_DSG_SETUP: rdata_reg <= dsg_setup_reg;
               `BAFE_ADDR_CHG_SETUP: rdata_reg <= chg_setup_reg;
               `BAFE_ADDR_FEATURE: rdata_reg <= feature_reg;
               `BAFE_ADDR_UNLOCK: rdata_reg <= unlock_reg;
               default: rdata_reg <= 8'h00; // Reserved range
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign link.ack = ack_reg;
   assign link.rdata = rdata_reg;
   assign cell_balance_out = cell_bal_reg;
   assign analog_sel_out = ana_out_reg[3:0];
   assign charge_switch_drive_out = fet_ctl_reg[`BAFE_FET_CHG_BIT];
   assign discharge_switch_drive_out = fet_ctl_reg[`BAFE_FET_DSG_BIT];
   assign sleep_out = fet_ctl_reg[`BAFE_FET_SLEEP_BIT];
   assign load_monitor_connect_en_out = fet_ctl_reg[`BAFE_FET_LDMON_BIT];
   assign discharge_setup_out = dsg_setup_reg;
   assign charge_setup_out = chg_setup_reg;
   assign feature_config_out = feature_reg;

endmodule : bafe_device

// ### rtl/bafe_host.sv
/*
 Host end of the register link: masks reserved bits, refuses reserved writes.
 Assumes one ack per request.
*/
`include "bafe_defs.svh"

module bafe_host (
   input wire logic clk_sys_in, // System clock
   input wire logic arst_n_in, // Async reset, active low
   bafe_link_if.host link, // Register link
   input wire logic cmd_valid_in, // Command strobe
   input wire bafe_pkg::bafe_op_e cmd_op_in, // Read or write
   input wire bafe_pkg::bafe_byte_t cmd_addr_in, // Register index
   input wire bafe_pkg::bafe_byte_t cmd_wdata_in, // Write byte
   output logic cmd_ready_out, // Idle, command accepted
   output logic done_out, // Completion pulse
   output logic refused_out, // Command refused pulse
   output bafe_pkg::bafe_byte_t rdata_out // Read byte, reserved bits zero
);
   import bafe_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef enum logic {bafe_idle, bafe_wait} bafe_state_e;
   bafe_state_e state_reg; // Transfer state
   logic req_reg; // Request to device
   bafe_op_e op_reg; // Held op
   bafe_byte_t addr_reg; // Held index
   bafe_byte_t wdata_reg; // Held data
   logic done_reg; // Done pulse
   logic refused_reg; // Refused pulse
   bafe_byte_t rdata_reg; // Masked read byte
   logic ready_reg; // Idle flag

   // Reserved bits of writable registers
   function automatic bafe_byte_t wr_mask(input bafe_byte_t a);
      unique case (a)
         `BAFE_ADDR_CELL_BAL: wr_mask = `BAFE_MASK_CELL_BAL;
         `BAFE_ADDR_ANA_OUT: wr_mask = `BAFE_MASK_ANA_OUT;
         `BAFE_ADDR_FET_CTL: wr_mask = `BAFE_MASK_FET_CTL;
         `BAFE_ADDR_UNLOCK: wr_mask = `BAFE_MASK_UNLOCK;
         default: wr_mask = 8'hff;
      endcase
   endfunction : wr_mask

   // Meaningful bits on read, the rest discarded
   function automatic bafe_byte_t rd_mask(input bafe_byte_t a);
      unique case (a)
         `BAFE_ADDR_CFG_WAKE: rd_mask = 8'h30;
         `BAFE_ADDR_PROT_STAT: rd_mask = 8'h3f;
         `BAFE_ADDR_CELL_BAL: rd_mask = `BAFE_MASK_CELL_BAL;
         `BAFE_ADDR_ANA_OUT: rd_mask = `BAFE_MASK_ANA_OUT;
         `BAFE_ADDR_FET_CTL: rd_mask = `BAFE_MASK_FET_CTL;
         `BAFE_ADDR_UNLOCK: rd_mask = `BAFE_MASK_UNLOCK;
         default: rd_mask = 8'hff;
      endcase
   endfunction : rd_mask

   // ----------------------------------------------------------------
   // Transfer sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_reg <= bafe_idle;
         req_reg <= 1'b0;
         op_reg <= bafe_op_read;
         addr_reg <= 8'h00;
         wdata_reg <= 8'h00;
         done_reg <= 1'b0;
         refused_reg <= 1'b0;
         rdata_reg <= 8'h00;
         ready_reg <= 1'b1;
      end else begin
         done_reg <= 1'b0;
         refused_reg <= 1'b0;
         req_reg <= 1'b0;
         unique case (state_reg)
            bafe_idle: begin
               if (cmd_valid_in) begin
                  if (cmd_op_in == bafe_op_write && cmd_addr_in > `BAFE_ADDR_LAST) begin
                     refused_reg <= 1'b1;
                  end else begin
                     op_reg <= cmd_op_in;
                     addr_reg <= cmd_addr_in;
                     wdata_reg <= cmd_wdata_in & wr_mask(cmd_addr_in);
                     req_reg <= 1'b1;
                     ready_reg <= 1'b0;
                     state_reg <= bafe_wait;
                  end
               end
            end
            bafe_wait: begin
               if (link.ack) begin
                  rdata_reg <= (op_reg == bafe_op_read) ?
                     (link.rdata & rd_mask(addr_reg)) : 8'h00;
                  done_reg <= 1'b1;
                  ready_reg <= 1'b1;
                  state_reg <= bafe_idle;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign link.req = req_reg;
   assign link.op = op_reg;
   assign link.addr = addr_reg;
   assign link.wdata = wdata_reg;
   assign cmd_ready_out = ready_reg;
   assign done_out = done_reg;
   assign refused_out = refused_reg;
   assign rdata_out = rdata_reg;

endmodule : bafe_host

// ### test/bafe_props.sv
/*
 Checker for the host-device register link.
 Assumes one clock domain and the plain signals of bafe_link_if.
*/
`include "bafe_defs.svh"

module bafe_props (
   input wire logic clk_sys_in, // System clock
   input wire logic arst_n_in, // Async reset, active low
   input wire logic req, // Request pulse
   input wire bafe_pkg::bafe_op_e op, // Transfer kind
   input wire bafe_pkg::bafe_byte_t addr, // Register index
   input wire bafe_pkg::bafe_byte_t wdata, // Write byte
   input wire logic ack, // Answer pulse
   input wire bafe_pkg::bafe_byte_t rdata // Read byte
);
   import bafe_pkg::*;
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Bits that may be one; setups keep all eight
   function automatic bafe_byte_t wmask(input bafe_byte_t a);
      case (a)
         `BAFE_ADDR_CELL_BAL: wmask = `BAFE_MASK_CELL_BAL;
         `BAFE_ADDR_ANA_OUT: wmask = `BAFE_MASK_ANA_OUT;
         `BAFE_ADDR_FET_CTL: wmask = `BAFE_MASK_FET_CTL;
         `BAFE_ADDR_UNLOCK: wmask = `BAFE_MASK_UNLOCK;
         default: wmask = 8'hff;
      endcase
   endfunction : wmask
   logic rd_ack; // Answer to a read
   logic wr_req; // Write request
   assign rd_ack = ack && (op == bafe_op_read);
   assign wr_req = req && (op == bafe_op_write);
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!arst_n_in);
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_ack_after_req: assert property (req |=> ack)
      else $error("ack not one cycle after req");
   a_ack_has_cause: assert property (ack |-> $past(req))
      else $error("ack without req");
   // One transfer in flight, so requests sit at least three cycles apart
   a_req_spacing: assert property (req |=> !req [*2])
      else $error("requests too close");
   a_write_in_range: assert property (wr_req |-> addr <= `BAFE_ADDR_LAST)
      else $error("write to reserved index");
   a_write_reserved_zero: assert property (wr_req |-> (wdata & ~wmask(addr)) == 8'h00)
      else $error("reserved write bit set");
   a_cfg_one_bit: assert property (rd_ack && addr == 8'h00 |-> rdata[5])
      else $error("fixed one bit low");
   a_bank_read_mask: assert property (rd_ack |-> (rdata & ~wmask(addr)) == 8'h00 || addr < 8'h02
      || addr > 8'h04 && addr != 8'h08)
      else $error("reserved read bit set");
   a_gap_read_zero: assert property (rd_ack && addr > 8'h08 |-> rdata == 8'h00)
      else $error("reserved index read nonzero");
   c_status_read: cover property (rd_ack && addr == 8'h01);
   c_fet_write: cover property (wr_req && addr == 8'h04);
   c_setup_write: cover property (wr_req && addr == 8'h05);
endmodule : bafe_props

// ### test/tb_top.sv
/*
 Bench for host and device on the link, plus a raw-driven second device.
 Assumes pkg/ and rtl/ compiled first, pkg/ on the include path.
*/
`define CHK(got, exp, msg) begin samples_checked++; if ((got) !== (exp)) begin fail_count++; \
   $display("unexpected %0t %s got %h exp %h", $time, msg, got, exp); end end

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import bafe_pkg::*;
   logic clk_sys_in = 1'b0; // System clock
   logic arst_n_in = 1'b0; // Reset, active low
   logic cmd_valid = 1'b0; // Command strobe
   bafe_op_e cmd_op = bafe_op_read; // Command kind
   bafe_byte_t cmd_addr = 8'h00; // Command index
   bafe_byte_t cmd_wdata = 8'h00; // Command byte
   logic cmd_ready, done, refused, chg_drv, dsg_drv, sleep, ldmon; // Observed levels
   bafe_byte_t bal, dset, cset, feat; // Register outputs
   logic [3:0] asel; // Analog select
   bafe_byte_t rdata; // Host read byte
   logic wake = 1'b0, external_overtemp_flag = 1'b0, internal_overtemp_flag = 1'b0, discharge_short_flag = 1'b0, discharge_overcurrent_flag = 1'b0, charge_overcurrent_flag = 1'b0; // Conditions
   bafe_byte_t shadow [0:8]; // Expected contents
   int fail_count = 0, samples_checked = 0, cycles = 0; // Counters
   bafe_link_if link ();
   bafe_link_if link_b ();
   bafe_host u_bafe_host (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .link(link.host),
      .cmd_valid_in(cmd_valid), .cmd_op_in(cmd_op), .cmd_addr_in(cmd_addr),
      .cmd_wdata_in(cmd_wdata), .cmd_ready_out(cmd_ready), .done_out(done),
      .refused_out(refused), .rdata_out(rdata));
   bafe_device u_bafe_device (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .link(link.dev),
      .wake_pin_in(wake), .ext_overtemp_in(external_overtemp_flag), .int_overtemp_in(internal_overtemp_flag), .dsg_short_in(discharge_short_flag),
      .dsg_overcurrent_in(discharge_overcurrent_flag), .chg_overcurrent_in(charge_overcurrent_flag), .cell_balance_out(bal),
      .analog_sel_out(asel), .charge_switch_drive_out(chg_drv),
      .discharge_switch_drive_out(dsg_drv), .sleep_out(sleep),
      .load_monitor_connect_en_out(ldmon), .discharge_setup_out(dset),
      .charge_setup_out(cset), .feature_config_out(feat));
   // Second device: the bench plays a careless host on link_b
   bafe_device u_bafe_device_b (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
      .link(link_b.dev), .wake_pin_in(wake), .ext_overtemp_in(external_overtemp_flag), .int_overtemp_in(internal_overtemp_flag),
      .dsg_short_in(discharge_short_flag), .dsg_overcurrent_in(discharge_overcurrent_flag), .chg_overcurrent_in(charge_overcurrent_flag),
      .cell_balance_out(), .analog_sel_out(), .charge_switch_drive_out(),
      .discharge_switch_drive_out(), .sleep_out(), .load_monitor_connect_en_out(),
      .discharge_setup_out(), .charge_setup_out(), .feature_config_out());
   bafe_props u_bafe_props (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .req(link.req),
      .op(link.op), .addr(link.addr), .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata));
   // ----------------------------------------------------------------
   // Clock, timeout and helpers
   // ----------------------------------------------------------------
   initial begin
      forever #2 clk_sys_in = ~clk_sys_in;
   end
   // Run needs about 350 cycles; a hang stops here
   always @(posedge clk_sys_in) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         $display("unexpected %0t timeout", $time);
         finish_test();
      end
   end
   // Bits that read back through the host
   function automatic bafe_byte_t rmask(input bafe_byte_t a);
      case (a)
         8'h00: rmask = 8'h30;
         8'h01: rmask = 8'h3f;
         8'h02: rmask = 8'h7e;
         8'h03: rmask = 8'hcf;
         8'h04: rmask = 8'hc3;
         8'h08: rmask = 8'hf8;
         default: rmask = 8'hff;
      endcase
   endfunction : rmask
   task automatic xfer(input bafe_op_e op, input bafe_byte_t a, input bafe_byte_t d);
      int n = 0;
      @(posedge clk_sys_in);
      #1;
      cmd_valid = 1'b1;
      cmd_op = op;
      cmd_addr = a;
      cmd_wdata = d;
      @(posedge clk_sys_in);
      #1;
      cmd_valid = 1'b0;
      while (done !== 1'b1 && refused !== 1'b1 && n < 8) begin
         @(posedge clk_sys_in);
         #1;
         n++;
      end
      `CHK({n < 8, cmd_ready}, 2'b11, "no completion")
   endtask : xfer
   // Setups only take the write while their unlock bit is set
   task automatic wr(input bafe_byte_t a, input bafe_byte_t d);
      xfer(bafe_op_write, a, d);
      if (a inside {8'h02, 8'h03, 8'h04, 8'h08} || a inside {[5:7]} && shadow[8][a[2:0]]) begin
         shadow[a[3:0]] = d & rmask(a);
      end
   endtask : wr
   task automatic rd(input bafe_byte_t a, input bafe_byte_t e);
      xfer(bafe_op_read, a, 8'h00);
      `CHK(rdata, e & rmask(a), "read")
   endtask : rd
   task automatic pulse(ref logic s);
      @(posedge clk_sys_in);
      #1;
      s = 1'b1;
      @(posedge clk_sys_in);
      #1;
      s = 1'b0;
      @(posedge clk_sys_in);
      #1;
   endtask : pulse
   // One direct transfer on link_b, request held for one cycle
   task automatic raw(input bafe_op_e op, input bafe_byte_t a, input bafe_byte_t d);
      @(posedge clk_sys_in);
      #1;
      link_b.req = 1'b1;
      link_b.op = op;
      link_b.addr = a;
      link_b.wdata = d;
      @(posedge clk_sys_in);
      #1;
      link_b.req = 1'b0;
   endtask : raw
   task automatic finish_test();
      $display("checked %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : finish_test
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      bafe_byte_t a;
      link_b.req = 1'b0;
      void'($urandom(85));
      shadow = '{7: 8'h01, default: 8'h00};
      repeat (10) @(posedge clk_sys_in);
      #1;
      arst_n_in = 1'b1;
      for (int i = 0; i < 9; i++) rd(8'(i), i ? shadow[i] : 8'h20);
      $display("test reset done");
      for (int i = 0; i < 16; i++) begin
         a = 8'($urandom_range(8, 2));
         wr(a, 8'($urandom) & rmask(a));
         rd(a, shadow[a[3:0]]);
         `CHK({bal, asel, ldmon}, {shadow[2], shadow[3][3:0], shadow[4][6]}, "outs")
         `CHK({dset, cset, feat}, {shadow[5], shadow[6], shadow[7]}, "setups")
      end
      $display("test random done");
      for (int j = 0; j < 2; j++) begin
         wr(8'h08, j ? 8'he0 : 8'h00);
         for (int i = 5; i < 8; i++) begin
            wr(8'(i), j ? 8'h0a + 8'(i) : ~shadow[i]);
            rd(8'(i), shadow[i]);
         end
      end
      $display("test unlock done");
      wr(8'h04, 8'h43);
      `CHK({chg_drv, dsg_drv}, 2'b11, "drive on")
      pulse(charge_overcurrent_flag);
      `CHK({chg_drv, dsg_drv}, 2'b00, "trip")
      shadow[4] = 8'h40;
      rd(8'h04, shadow[4]);
      rd(8'h01, 8'h01);
      rd(8'h01, 8'h00);
      pulse(discharge_overcurrent_flag);
      rd(8'h01, 8'h0a);
      wr(8'h04, 8'h00);
      pulse(discharge_overcurrent_flag);
      pulse(discharge_short_flag);
      rd(8'h01, 8'h06);
      external_overtemp_flag = 1'b1;
      internal_overtemp_flag = 1'b1;
      rd(8'h01, 8'h30);
      rd(8'h01, 8'h30);
      external_overtemp_flag = 1'b0;
      internal_overtemp_flag = 1'b0;
      rd(8'h01, 8'h30);
      rd(8'h01, 8'h00);
      $display("test protection done");
      wake = 1'b1;
      rd(8'h00, 8'h30);
      wr(8'h07, 8'h10);
      rd(8'h00, 8'h20);
      wr(8'h04, 8'h80);
      wake = 1'b0;
      rd(8'h00, 8'h30);
      `CHK(sleep, 1'b0, "wake fall")
      wr(8'h04, 8'h80);
      wake = 1'b1;
      repeat (3) @(posedge clk_sys_in);
      `CHK(sleep, 1'b1, "wrong edge")
      wr(8'h04, 8'h00);
      `CHK(sleep, 1'b0, "write zero")
      xfer(bafe_op_write, 8'h09, 8'h5a);
      `CHK(refused, 1'b1, "refuse")
      rd(8'h0a, 8'h00);
      $display("test sleep done");
      foreach (shadow[i]) begin
         if (i inside {2, 3, 4, 8}) begin
            raw(bafe_op_write, 8'(i), 8'hff);
            raw(bafe_op_read, 8'(i), 8'h00);
            `CHK(link_b.rdata, rmask(8'(i)), "reserved bits")
         end
      end
      raw(bafe_op_write, 8'h0a, 8'hff);
      raw(bafe_op_read, 8'h0a, 8'h00);
      `CHK(link_b.rdata, 8'h00, "reserved index")
      $display("test careless host done");
      finish_test();
   end
endmodule : tb_top
